/* verilog/rtc_i2c_read_and_comp_ctrl.sv */
// Contract
// - device acknowledges both id bytes and the word address of a read
// - device keeps sending bytes while master acknowledges after each eighth bit
// - pointer loads from word address and advances by one per sent byte
// - pointer wraps from 2Fh to 00h; sending continues for every acknowledge
// - serial bus ignored on backup supply; registers and memory kept
// - factory calibration copied into calibration registers at power-up
// - low five bits of 0Dh hold factory trim loaded at power-up
// - writes to 0Dh change only control bits, never the trim field
// - bit 7 of 0Dh enables correction every 60 seconds on main power
// - bits 5 and 6 of 0Dh select compensation in battery mode
// - write to 0Dh with enable set starts a compensation cycle
// - registers 0Bh and 0Ch are read-only; writes ignored
// - time moves ahead at forward point and back at reverse point
// - daylight-saving enable sits in forward month register 15h
// - week/day registers hold week, weekday and a week/day select bit
// - forward and reverse hours are plain BCD without 24-hour select
// - week value seven means last given weekday of the month
// - forward flag set after forward, cleared by reverse, power-up, disable
// - accept ids 1101111 and 1010111; acknowledge only on match
// - every byte moves most significant bit first
// - address pointer is 00h after power-up
`timescale 1ns/1ps
module rtc_i2c_read_and_comp_ctrl #(
	parameter longint COMP_PERIOD_CYCLES = rtc_pkg::COMP_PERIOD_CYC
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_srst,
	input  wire logic              i_link_clk,
	input  wire logic              i_scl,
	input  wire logic              i_sda,
	output logic                   o_sda_out,
	output logic                   o_sda_oe,
	input  wire logic              i_on_battery,
	input  wire rtc_pkg::factory_t i_factory,
	input  wire rtc_pkg::now_t     i_now,
	input  wire logic [9:0]        i_temperature,
	output logic                   o_step_fwd,
	output logic                   o_step_back,
	output rtc_pkg::trim_t         o_trim
);
	// ---------------- link domain ----------------
	logic [1:0]          rst_sy;
	logic                link_rst;
	logic [2:0]          scl_sy;
	logic [2:0]          sda_sy;
	logic [2:0]          bat_sy;
	logic                scl_f_q;
	logic                sda_f_q;
	logic                bat_f_q;
	logic                scl_p_q;
	logic                sda_p_q;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_ev;
	logic                stop_ev;
	logic                run_ok;
	rtc_pkg::bus_state_t state_q;
	rtc_pkg::byte_kind_t kind_q;
	logic [2:0]          cnt_q;
	logic [7:0]          sh_q;
	logic                full_q;
	logic                user_q;
	logic                after_tx_q;
	logic                mack_q;
	logic [7:0]          tx_q;
	logic [7:0]          ptr_q;
	logic [7:0]          rd_data;
	logic                byte_ev;
	logic                id_ok;
	logic                load_tx;
	logic                wr_ev;
	logic [7:0]          rtc_q [0:rtc_pkg::RTC_DEPTH-1];
	logic [7:0]          user_mem [0:rtc_pkg::USER_DEPTH-1];
	logic                init_q;
	logic                kick_tgl_q;
	rtc_pkg::cfg_t       cfg_live;
	rtc_pkg::cfg_t       cfg_q;
	logic                cfg_req_q;
	logic [1:0]          cfg_ack_sy;
	logic [1:0]          stat_req_sy;
	logic                stat_ack_q;
	rtc_pkg::stat_t      stat_copy_q;
	logic                cfg_ack_q;
	logic                stat_req_q;
	rtc_pkg::stat_t      stat_out_q;

	function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic user);
		if (user)
			next_ptr = {1'b0, 7'(p[6:0] + 7'h01)};
		else if (p >= rtc_pkg::OFF_RTC_LAST)
			next_ptr = rtc_pkg::RST_PTR;
		else
			next_ptr = 8'(p + 8'h01);
	endfunction

	// reset level crosses with two stages; only the second is used
	always_ff @(posedge i_link_clk) begin
		rst_sy <= {rst_sy[0], i_srst};
	end
	assign link_rst = rst_sy[1];

	always_ff @(posedge i_link_clk) begin
		scl_sy <= {scl_sy[1:0], i_scl};
		sda_sy <= {sda_sy[1:0], i_sda};
		bat_sy <= {bat_sy[1:0], i_on_battery};
	end

	// a pin change counts only when stages two and three agree
	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			bat_f_q <= 1'b0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			if (scl_sy[1] == scl_sy[2])
				scl_f_q <= scl_sy[2];
			if (sda_sy[1] == sda_sy[2])
				sda_f_q <= sda_sy[2];
			if (bat_sy[1] == bat_sy[2])
				bat_f_q <= bat_sy[2];
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	always_comb begin
		scl_rise = scl_f_q & ~scl_p_q;
		scl_fall = ~scl_f_q & scl_p_q;
		start_ev = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
		stop_ev  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
		run_ok   = ~start_ev & ~stop_ev & ~bat_f_q;
		byte_ev  = run_ok & scl_fall & (state_q == rtc_pkg::ST_RX) & full_q;
		id_ok    = (sh_q[7:1] == rtc_pkg::ID_RTC) | (sh_q[7:1] == rtc_pkg::ID_USER);
		wr_ev    = byte_ev & (kind_q == rtc_pkg::K_DATA);
		load_tx  = run_ok & scl_fall & (((state_q == rtc_pkg::ST_ACK) & after_tx_q)
			| ((state_q == rtc_pkg::ST_MACK) & mack_q));
	end

	always_comb begin
		rd_data = rtc_pkg::RST_BYTE;
		if (user_q)
			rd_data = user_mem[ptr_q[6:0]];
		else if (ptr_q == rtc_pkg::OFF_STATUS)
			rd_data = 8'(stat_copy_q.flag) << rtc_pkg::BIT_FLAG;
		else if (ptr_q == rtc_pkg::OFF_ATR)
			rd_data = stat_copy_q.trim.atr;
		else if (ptr_q == rtc_pkg::OFF_DTR)
			rd_data = stat_copy_q.trim.dtr;
		else if (ptr_q <= rtc_pkg::OFF_RTC_LAST)
			rd_data = rtc_q[ptr_q[5:0]];
	end

	// bus state machine; on backup supply every bus event is dropped
	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			state_q    <= rtc_pkg::ST_IDLE;
			kind_q     <= rtc_pkg::K_ID;
			cnt_q      <= 3'h0;
			sh_q       <= rtc_pkg::RST_BYTE;
			full_q     <= 1'b0;
			user_q     <= 1'b0;
			after_tx_q <= 1'b0;
			mack_q     <= 1'b0;
			tx_q       <= rtc_pkg::RST_BYTE;
			o_sda_oe   <= 1'b0;
		end else if (bat_f_q | stop_ev) begin
			state_q  <= rtc_pkg::ST_IDLE;
			o_sda_oe <= 1'b0;
		end else if (start_ev) begin
			state_q  <= rtc_pkg::ST_RX;
			kind_q   <= rtc_pkg::K_ID;
			cnt_q    <= 3'h0;
			full_q   <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (load_tx) begin
			tx_q     <= rd_data;
			o_sda_oe <= ~rd_data[7];
			cnt_q    <= 3'h0;
			state_q  <= rtc_pkg::ST_TX;
		end else begin
			case (state_q)
				rtc_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_q   <= {sh_q[6:0], sda_f_q};
						cnt_q  <= 3'(cnt_q + 3'h1);
						full_q <= (cnt_q == 3'h7);
					end else if (byte_ev) begin
						full_q <= 1'b0;
						if (kind_q == rtc_pkg::K_ID) begin
							if (id_ok) begin
								o_sda_oe   <= 1'b1;
								state_q    <= rtc_pkg::ST_ACK;
								user_q     <= (sh_q[7:1] == rtc_pkg::ID_USER);
								after_tx_q <= sh_q[0];
								kind_q     <= rtc_pkg::K_WORD;
							end else begin
								state_q <= rtc_pkg::ST_IDLE;
							end
						end else begin
							o_sda_oe   <= 1'b1;
							state_q    <= rtc_pkg::ST_ACK;
							after_tx_q <= 1'b0;
							kind_q     <= rtc_pkg::K_DATA;
						end
					end
				end
				rtc_pkg::ST_ACK: begin
					if (scl_fall) begin
						o_sda_oe <= 1'b0;
						cnt_q    <= 3'h0;
						state_q  <= rtc_pkg::ST_RX;
					end
				end
				rtc_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == 3'h7) begin
							o_sda_oe <= 1'b0;
							state_q  <= rtc_pkg::ST_MACK;
						end else begin
							tx_q     <= {tx_q[6:0], 1'b0};
							o_sda_oe <= ~tx_q[6];
							cnt_q    <= 3'(cnt_q + 3'h1);
						end
					end
				end
				rtc_pkg::ST_MACK: begin
					if (scl_rise)
						mack_q <= ~sda_f_q;
					else if (scl_fall)
						state_q <= rtc_pkg::ST_IDLE;
				end
				default: state_q <= rtc_pkg::ST_IDLE;
			endcase
		end
	end

	// data line is open drain: value low, enable pulls
	always_ff @(posedge i_link_clk) begin
		o_sda_out <= 1'b0;
	end

	always_ff @(posedge i_link_clk) begin
		if (link_rst)
			ptr_q <= rtc_pkg::RST_PTR;
		else if (byte_ev & (kind_q == rtc_pkg::K_WORD))
			ptr_q <= sh_q;
		else if (wr_ev | load_tx)
			ptr_q <= next_ptr(ptr_q, user_q);
	end

	// user memory is not reset: its contents outlive the bus
	always_ff @(posedge i_link_clk) begin
		if (wr_ev & user_q)
			user_mem[ptr_q[6:0]] <= sh_q;
	end

	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			for (int i = 0; i < rtc_pkg::RTC_DEPTH; i++)
				rtc_q[i] <= rtc_pkg::RST_BYTE;
			init_q     <= 1'b0;
			kick_tgl_q <= 1'b0;
		end else if (!init_q) begin
			init_q                      <= 1'b1;
			rtc_q[rtc_pkg::OFF_ITRIM[5:0]] <= i_factory.itrim;
			rtc_q[rtc_pkg::OFF_ALPHA[5:0]] <= i_factory.alpha;
			rtc_q[rtc_pkg::OFF_TRIM[5:0]]  <= {3'h0, i_factory.trim};
		end else if (wr_ev & ~user_q & (ptr_q <= rtc_pkg::OFF_RTC_LAST)) begin
			if (ptr_q == rtc_pkg::OFF_TRIM) begin
				rtc_q[ptr_q[5:0]] <= {sh_q[7:rtc_pkg::TRIM_W],
					rtc_q[ptr_q[5:0]][rtc_pkg::TRIM_W-1:0]};
				if (sh_q[rtc_pkg::BIT_TSE])
					kick_tgl_q <= ~kick_tgl_q;
			end else if ((ptr_q < rtc_pkg::OFF_STATUS) | (ptr_q > rtc_pkg::OFF_TRIM)) begin
				rtc_q[ptr_q[5:0]] <= sh_q;
			end
		end
	end

	always_comb begin
		cfg_live.dst.fwd_month = rtc_q[rtc_pkg::OFF_FWD_MONTH[5:0]];
		cfg_live.dst.fwd_wd    = rtc_q[rtc_pkg::OFF_FWD_WD[5:0]];
		cfg_live.dst.fwd_date  = rtc_q[rtc_pkg::OFF_FWD_DATE[5:0]];
		cfg_live.dst.fwd_hour  = rtc_q[rtc_pkg::OFF_FWD_HOUR[5:0]];
		cfg_live.dst.rev_month = rtc_q[rtc_pkg::OFF_REV_MONTH[5:0]];
		cfg_live.dst.rev_wd    = rtc_q[rtc_pkg::OFF_REV_WD[5:0]];
		cfg_live.dst.rev_date  = rtc_q[rtc_pkg::OFF_REV_DATE[5:0]];
		cfg_live.dst.rev_hour  = rtc_q[rtc_pkg::OFF_REV_HOUR[5:0]];
		cfg_live.ctrl          = rtc_q[rtc_pkg::OFF_TRIM[5:0]][7:rtc_pkg::TRIM_W];
		cfg_live.kick          = kick_tgl_q;
	end

	// words cross by toggle handshake; held word stays still until ack returns
	always_ff @(posedge i_link_clk) begin
		cfg_ack_sy  <= {cfg_ack_sy[0], cfg_ack_q};
		stat_req_sy <= {stat_req_sy[0], stat_req_q};
	end

	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			cfg_q     <= '0;
			cfg_req_q <= 1'b0;
		end else if ((cfg_req_q == cfg_ack_sy[1]) && (cfg_live != cfg_q)) begin
			cfg_q     <= cfg_live;
			cfg_req_q <= ~cfg_req_q;
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			stat_copy_q <= '0;
			stat_ack_q  <= 1'b0;
		end else if (stat_req_sy[1] != stat_ack_q) begin
			stat_copy_q <= stat_out_q;
			stat_ack_q  <= stat_req_sy[1];
		end
	end

	// ---------------- core domain ----------------
	logic [2:0]     cbat_sy;
	logic           cbat_q;
	logic [1:0]     cfg_req_sy;
	rtc_pkg::cfg_t  cfg_core_q;
	logic           kick_q;
	logic [1:0]     stat_ack_sy;
	rtc_pkg::stat_t stat_live;
	logic           flag_q;
	logic [30:0]    tmr_q;
	logic           comp_run;
	logic           comp_go;
	logic [9:0]     last_temp_q;
	logic           dst_en;
	logic           fwd_hit;
	logic           rev_hit;

	function automatic logic dst_match(input logic [7:0] mon, input logic [7:0] wd,
		input logic [7:0] date, input logic [7:0] hour, input rtc_pkg::now_t now);
		logic day_ok;
		day_ok = 1'b0;
		if (wd[rtc_pkg::BIT_WD_SEL])
			day_ok = (wd[2:0] == now.weekday) && ((wd[5:3] == now.week)
				|| ((wd[5:3] == rtc_pkg::WEEK_LAST) && now.last_week));
		else
			day_ok = (date == now.date);
		dst_match = day_ok && (mon[4:0] == now.month[4:0])
			&& (hour[5:0] == now.hour[5:0]);
	endfunction

	always_ff @(posedge i_core_clk) begin
		cbat_sy     <= {cbat_sy[1:0], i_on_battery};
		cfg_req_sy  <= {cfg_req_sy[0], cfg_req_q};
		stat_ack_sy <= {stat_ack_sy[0], stat_ack_q};
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst)
			cbat_q <= 1'b0;
		else if (cbat_sy[1] == cbat_sy[2])
			cbat_q <= cbat_sy[2];
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			cfg_core_q <= '0;
			cfg_ack_q  <= 1'b0;
			kick_q     <= 1'b0;
		end else begin
			kick_q <= 1'b0;
			if (cfg_req_sy[1] != cfg_ack_q) begin
				cfg_core_q <= cfg_q;
				cfg_ack_q  <= cfg_req_sy[1];
				kick_q     <= (cfg_q.kick != cfg_core_q.kick) && cfg_q.ctrl[2];
			end
		end
	end

	// battery mode runs only if one of the two mode bits is set
	always_comb begin
		comp_run = cfg_core_q.ctrl[2] && (!cbat_q || (cfg_core_q.ctrl[1:0] != 2'h0));
		comp_go  = kick_q || (comp_run && (tmr_q == 31'(COMP_PERIOD_CYCLES - 1)));
		dst_en   = cfg_core_q.dst.fwd_month[rtc_pkg::BIT_DST_EN];
		fwd_hit  = dst_match(cfg_core_q.dst.fwd_month, cfg_core_q.dst.fwd_wd,
			cfg_core_q.dst.fwd_date, cfg_core_q.dst.fwd_hour, i_now);
		rev_hit  = dst_match(cfg_core_q.dst.rev_month, cfg_core_q.dst.rev_wd,
			cfg_core_q.dst.rev_date, cfg_core_q.dst.rev_hour, i_now);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst || !comp_run || comp_go)
			tmr_q <= 31'h0;
		else
			tmr_q <= 31'(tmr_q + 31'h1);
	end

	// new correction only when the temperature moved since the last cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_trim      <= '0;
			last_temp_q <= rtc_pkg::RST_TEMP;
		end else if (comp_go && (i_temperature != last_temp_q)) begin
			o_trim.atr  <= {2'h0, i_temperature[9:4]};
			o_trim.dtr  <= {3'h0, i_temperature[4:0]};
			last_temp_q <= i_temperature;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			flag_q      <= 1'b0;
			o_step_fwd  <= 1'b0;
			o_step_back <= 1'b0;
		end else begin
			o_step_fwd  <= 1'b0;
			o_step_back <= 1'b0;
			if (!dst_en) begin
				flag_q <= 1'b0;
			end else if (fwd_hit && !flag_q) begin
				flag_q     <= 1'b1;
				o_step_fwd <= 1'b1;
			end else if (rev_hit && flag_q) begin
				flag_q      <= 1'b0;
				o_step_back <= 1'b1;
			end
		end
	end

	assign stat_live = {flag_q, o_trim};

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			stat_out_q <= '0;
			stat_req_q <= 1'b0;
		end else if ((stat_req_q == stat_ack_sy[1]) && (stat_live != stat_out_q)) begin
			stat_out_q <= stat_live;
			stat_req_q <= ~stat_req_q;
		end
	end
endmodule

/* verilog/rtc_pkg.sv */
package rtc_pkg;
	localparam logic [6:0]  ID_RTC        = 7'h6F;
	localparam logic [6:0]  ID_USER       = 7'h57;
	localparam logic [7:0]  OFF_STATUS    = 8'h08;
	localparam logic [7:0]  OFF_ATR       = 8'h09;
	localparam logic [7:0]  OFF_DTR       = 8'h0A;
	localparam logic [7:0]  OFF_ITRIM     = 8'h0B;
	localparam logic [7:0]  OFF_ALPHA     = 8'h0C;
	localparam logic [7:0]  OFF_TRIM      = 8'h0D;
	localparam logic [7:0]  OFF_FWD_MONTH = 8'h15;
	localparam logic [7:0]  OFF_FWD_WD    = 8'h16;
	localparam logic [7:0]  OFF_FWD_DATE  = 8'h17;
	localparam logic [7:0]  OFF_FWD_HOUR  = 8'h18;
	localparam logic [7:0]  OFF_REV_MONTH = 8'h19;
	localparam logic [7:0]  OFF_REV_WD    = 8'h1A;
	localparam logic [7:0]  OFF_REV_DATE  = 8'h1B;
	localparam logic [7:0]  OFF_REV_HOUR  = 8'h1C;
	localparam logic [7:0]  OFF_RTC_LAST  = 8'h2F;
	localparam int          RTC_DEPTH     = 48;
	localparam int          USER_DEPTH    = 128;
	localparam int          BIT_TSE       = 7;
	localparam int          BIT_DST_EN    = 7;
	localparam int          BIT_WD_SEL    = 6;
	localparam int          BIT_FLAG      = 5;
	localparam int          TRIM_W        = 5;
	localparam logic [2:0]  WEEK_LAST     = 3'h7;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [7:0]  RST_PTR       = 8'h00;
	localparam logic [9:0]  RST_TEMP      = 10'h3FF;
	localparam int          COMP_PERIOD_S = 60;
	localparam longint      CORE_CLK_HZ   = 20000000;
	localparam longint      COMP_PERIOD_CYC = longint'(COMP_PERIOD_S) * CORE_CLK_HZ;

	typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} bus_state_t;
	typedef enum {K_ID, K_WORD, K_DATA} byte_kind_t;

	typedef struct packed {
		logic [7:0] fwd_month;
		logic [7:0] fwd_wd;
		logic [7:0] fwd_date;
		logic [7:0] fwd_hour;
		logic [7:0] rev_month;
		logic [7:0] rev_wd;
		logic [7:0] rev_date;
		logic [7:0] rev_hour;
	} dst_set_t;

	typedef struct packed {
		dst_set_t   dst;
		logic [2:0] ctrl;
		logic       kick;
	} cfg_t;

	typedef struct packed {
		logic [7:0] atr;
		logic [7:0] dtr;
	} trim_t;

	typedef struct packed {
		logic  flag;
		trim_t trim;
	} stat_t;

	typedef struct packed {
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [2:0] weekday;
		logic [2:0] week;
		logic       last_week;
	} now_t;

	typedef struct packed {
		logic [4:0] trim;
		logic [7:0] itrim;
		logic [7:0] alpha;
	} factory_t;
endpackage

/* verification/rtc_ctrl_props.sv */
`timescale 1ns/1ps
module rtc_ctrl_props #(
	parameter longint COMP_PERIOD_CYCLES = 200
) (
	input wire logic           i_core_clk,
	input wire logic           i_srst,
	input wire logic           i_link_clk,
	input wire logic           i_scl,
	input wire logic           i_on_battery,
	input wire logic           o_sda_out,
	input wire logic           o_sda_oe,
	input wire logic           o_step_fwd,
	input wire logic           o_step_back,
	input wire rtc_pkg::trim_t o_trim
);
	logic last_fwd_q;

	// weaker after a disable, but never fires falsely
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			last_fwd_q <= 1'b0;
		end else if (o_step_fwd) begin
			last_fwd_q <= 1'b1;
		end else if (o_step_back) begin
			last_fwd_q <= 1'b0;
		end
	end

	property p_oe_scl_low;
		@(posedge i_link_clk) disable iff (i_srst)
		$changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 3);
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive changed off clock low");

	property p_batt_quiet;
		@(posedge i_link_clk) disable iff (i_srst)
		i_on_battery [*8] |-> !o_sda_oe;
	endproperty
	a_batt_quiet: assert property (p_batt_quiet) else $error("data line driven on battery");

	property p_drive_low;
		@(posedge i_link_clk) disable iff (i_srst)
		o_sda_oe |-> o_sda_out == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("data line driven high");

	property p_fwd_once;
		@(posedge i_core_clk) disable iff (i_srst)
		o_step_fwd |=> !o_step_fwd [*8];
	endproperty
	a_fwd_once: assert property (p_fwd_once) else $error("forward step repeated");

	property p_no_both;
		@(posedge i_core_clk) disable iff (i_srst)
		o_step_fwd |-> !o_step_back;
	endproperty
	a_no_both: assert property (p_no_both) else $error("both steps at once");

	property p_back_after_fwd;
		@(posedge i_core_clk) disable iff (i_srst)
		o_step_back |-> last_fwd_q;
	endproperty
	a_back_after_fwd: assert property (p_back_after_fwd) else $error("back without forward");

	property p_trim_form;
		@(posedge i_core_clk) disable iff (i_srst)
		$changed(o_trim) |-> o_trim.atr[7:6] == 2'b00 && o_trim.dtr[7:5] == 3'b000
			&& o_trim.atr[0] == o_trim.dtr[4];
	endproperty
	a_trim_form: assert property (p_trim_form) else $error("trim pair inconsistent");

	property p_reset_quiet;
		@(posedge i_core_clk) disable iff (i_srst)
		$fell(i_srst) |-> o_trim == 16'h0000 && !o_step_fwd && !o_step_back;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");

	c_fwd: cover property (@(posedge i_core_clk) o_step_fwd);
	c_back: cover property (@(posedge i_core_clk) o_step_back);
	c_ack: cover property (@(posedge i_link_clk) $rose(o_sda_oe));
endmodule

bind rtc_i2c_read_and_comp_ctrl rtc_ctrl_props #(
	.COMP_PERIOD_CYCLES(COMP_PERIOD_CYCLES)
) u_props (
	.i_core_clk(i_core_clk),
	.i_srst(i_srst),
	.i_link_clk(i_link_clk),
	.i_scl(i_scl),
	.i_on_battery(i_on_battery),
	.o_sda_out(o_sda_out),
	.o_sda_oe(o_sda_oe),
	.o_step_fwd(o_step_fwd),
	.o_step_back(o_step_back),
	.o_trim(o_trim)
);

/* verification/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic i_link_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	// link clocks per clock phase; raise to act as a slow master
	int half = 8;

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic hold();
		repeat (half) @(posedge i_link_clk);
	endtask

	// also serves as repeated start from a low clock
	task automatic start();
		@(posedge i_link_clk);
		o_sda_low <= 1'b0;
		hold();
		o_scl <= 1'b1;
		hold();
		o_sda_low <= 1'b1;
		hold();
		o_scl <= 1'b0;
		hold();
	endtask

	task automatic bit_io(input logic b, output logic r);
		o_sda_low <= ~b;
		hold();
		o_scl <= 1'b1;
		hold();
		r = i_sda;
		o_scl <= 1'b0;
		hold();
	endtask

	task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack);
	endtask

	task automatic stop();
		o_sda_low <= 1'b1;
		hold();
		o_scl <= 1'b1;
		hold();
		o_sda_low <= 1'b0;
		hold();
	endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam rtc_pkg::factory_t FACT = {5'h15, 8'h5A, 8'hC3};
	logic              i_core_clk, i_srst, i_link_clk, scl, sda_low, sda_wire;
	logic              o_sda_out, o_sda_oe, i_on_battery, o_step_fwd, o_step_back;
	rtc_pkg::factory_t i_factory;
	rtc_pkg::now_t     i_now;
	logic [9:0]        i_temperature;
	rtc_pkg::trim_t    o_trim;
	logic [7:0]        rdq[$];
	logic [7:0]        dstq[$] = {8'h84, 8'h48, 8'h00, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02};
	int                mismatches = 0, n_compared = 0, cycles = 0, n_fwd = 0, n_back = 0;

	assign sda_wire = (o_sda_oe ? o_sda_out : 1'b1) & ~sda_low;

	rtc_i2c_read_and_comp_ctrl #(.COMP_PERIOD_CYCLES(200)) dut (
		.i_core_clk(i_core_clk), .i_srst(i_srst), .i_link_clk(i_link_clk), .i_scl(scl),
		.i_sda(sda_wire), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
		.i_on_battery(i_on_battery), .i_factory(i_factory), .i_now(i_now),
		.i_temperature(i_temperature), .o_step_fwd(o_step_fwd), .o_step_back(o_step_back),
		.o_trim(o_trim)
	);
	i2c_master_model m (.i_link_clk(i_link_clk), .i_sda(sda_wire), .o_scl(scl),
		.o_sda_low(sda_low));

	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	// phase offset keeps the two domains unrelated
	initial begin
		i_link_clk = 1'b0;
		#7;
		forever #16 i_link_clk = ~i_link_clk;
	end

	always @(posedge i_core_clk) begin
		cycles++;
		if (o_step_fwd === 1'b1) n_fwd++;
		if (o_step_back === 1'b1) n_back++;
		if (cycles == 40000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] trim_of(input logic [9:0] t);
		return {2'b00, t[9:4], 3'b000, t[4:0]};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask

	task automatic rd(input logic [7:0] addr, input int n);
		logic [7:0] rx;
		logic       ack;
		rdq.delete();
		m.start();
		m.byte_io({rtc_pkg::ID_RTC, 1'b0}, 1'b1, rx, ack);
		check("ack id write", 16'h0000, {15'h0, ack});
		m.byte_io(addr, 1'b1, rx, ack);
		check("ack word", 16'h0000, {15'h0, ack});
		m.start();
		m.byte_io({rtc_pkg::ID_RTC, 1'b1}, 1'b1, rx, ack);
		check("ack id read", 16'h0000, {15'h0, ack});
		for (int i = 0; i < n; i++) begin
			m.byte_io(8'hFF, (i == n - 1), rx, ack);
			rdq.push_back(rx);
		end
		m.stop();
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] d[$]);
		logic [7:0] rx;
		logic       ack;
		m.start();
		m.byte_io({rtc_pkg::ID_RTC, 1'b0}, 1'b1, rx, ack);
		m.byte_io(addr, 1'b1, rx, ack);
		foreach (d[i]) m.byte_io(d[i], 1'b1, rx, ack);
		m.stop();
	endtask

	task automatic probe(input logic [6:0] id, input logic exp);
		logic [7:0] rx;
		logic       ack;
		m.start();
		m.byte_io({id, 1'b0}, 1'b1, rx, ack);
		m.stop();
		check("probe ack", {15'h0, exp}, {15'h0, ack});
	endtask

	initial begin
		i_srst = 1'b1;
		i_on_battery = 1'b0;
		i_factory = FACT;
		i_now = '0;
		i_temperature = 10'h123;
		// three edges; the link side still sees four
		cyc(3);
		i_srst <= 1'b0;
		cyc(1);
		check("trim after reset", 16'h0000, o_trim);
		cyc(20);
		rd(rtc_pkg::OFF_ITRIM, 3);
		check("itrim", {8'h0, FACT.itrim}, rdq[0]);
		check("alpha", {8'h0, FACT.alpha}, rdq[1]);
		check("trim reg", {11'h0, FACT.trim}, rdq[2]);
		wr(rtc_pkg::OFF_ITRIM, {8'hAA, 8'hBB, 8'hE0});
		rd(rtc_pkg::OFF_ITRIM, 3);
		check("itrim ro", {8'h0, FACT.itrim}, rdq[0]);
		check("alpha ro", {8'h0, FACT.alpha}, rdq[1]);
		check("trim locked", {8'h0, 3'b111, FACT.trim}, rdq[2]);
		cyc(60);
		check("trim on write", trim_of(10'h123), o_trim);
		i_temperature <= 10'h2C7;
		cyc(260);
		check("trim periodic", trim_of(10'h2C7), o_trim);
		wr(rtc_pkg::OFF_TRIM, {8'h80});
		cyc(60);
		i_on_battery <= 1'b1;
		i_temperature <= 10'h0A5;
		cyc(10);
		probe(rtc_pkg::ID_RTC, 1'b1);
		cyc(300);
		check("trim on battery", trim_of(10'h2C7), o_trim);
		i_on_battery <= 1'b0;
		cyc(300);
		check("trim main power", trim_of(10'h0A5), o_trim);
		probe(rtc_pkg::ID_USER, 1'b0);
		probe(7'h50, 1'b1);
		// nonzero battery mode keeps the periodic correction running
		wr(rtc_pkg::OFF_TRIM, {8'hE0});
		cyc(60);
		i_on_battery <= 1'b1;
		i_temperature <= 10'h155;
		cyc(300);
		check("trim battery mode", trim_of(10'h155), o_trim);
		i_on_battery <= 1'b0;
		cyc(20);
		m.half = 12;
		rd(8'h2F, 15);
		m.half = 8;
		check("wrap itrim", {8'h0, FACT.itrim}, rdq[12]);
		check("wrap trim", {8'h0, 3'b111, FACT.trim}, rdq[14]);
		wr(rtc_pkg::OFF_FWD_MONTH, dstq);
		rd(rtc_pkg::OFF_FWD_MONTH, 8);
		foreach (dstq[i]) check("dst reg", {8'h0, dstq[i]}, rdq[i]);
		i_now <= {8'h04, 8'h01, 8'h02, 3'h0, 3'h1, 1'b0};
		cyc(60);
		check("forward steps", 16'd1, n_fwd[15:0]);
		rd(rtc_pkg::OFF_STATUS, 1);
		check("flag set", 16'h0001, {15'h0, rdq[0][5]});
		i_now <= {8'h10, 8'h01, 8'h02, 3'h0, 3'h4, 1'b1};
		cyc(60);
		check("back steps", 16'd1, n_back[15:0]);
		rd(rtc_pkg::OFF_STATUS, 1);
		check("flag clear", 16'h0000, {15'h0, rdq[0][5]});
		i_now <= {8'h04, 8'h01, 8'h02, 3'h0, 3'h1, 1'b0};
		cyc(60);
		check("forward again", 16'd2, n_fwd[15:0]);
		wr(rtc_pkg::OFF_FWD_MONTH, {8'h04});
		cyc(60);
		rd(rtc_pkg::OFF_STATUS, 1);
		check("flag disabled", 16'h0000, {15'h0, rdq[0][5]});
		conclude();
	end
endmodule
